//--- pin_load_model.sv
// Purpose: far-side pins of the timer: capture source, fault pin, pwm loads
// Assumes: bench asks for pin levels through cap_req and fault_req
// Notes: fault pin has a pull-up, so a released pin reads high
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (
  input  wire logic       CLK,
  input  wire logic       cap_req,
  input  wire logic       fault_req,
  input  wire logic [3:0] PWM_OUT,
  input  wire logic [3:0] PWM_OUT_EN,
  output logic            CAPTURE_INPUT,
  output logic            FAULT_STOP_N
);
  // capture source changes just after an edge, like a synchronous pin driver
  always_ff @(posedge CLK) begin
    CAPTURE_INPUT <= cap_req;
  end
  // open pin floats to the pull-up level when nobody pulls it low
  assign FAULT_STOP_N = fault_req ? 1'b0 : 1'b1;
endmodule // pin_load_model
`default_nettype wire

//--- reload_timer.sv
// Purpose: twelve-bit auto-reload timer with four pwm outputs and capture
// Assumes: all inputs synchronous to CLK; power state given as level inputs
// Notes: registers are reached over AHB-Lite, zero wait states for writes, one wait state for reads
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module reload_timer
  import reload_timer_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        SLOW_MODE,
  input  wire logic        IDLE_MODE,
  input  wire logic        STOP_MODE,
  input  wire logic        TIMED_STOP_MODE,
  input  wire logic        CAPTURE_INPUT,
  input  wire logic        FAULT_STOP_N,
  output logic      [3:0]  PWM_OUT,
  output logic      [3:0]  PWM_OUT_EN
);
  typedef enum {PH_IDLE, PH_DATA} phase_t;
  phase_t      phase_reg;
  bus_req_t    req_reg;
  logic [11:0] reload_value_reg;
  logic [11:0] up_count_reg;
  logic [11:0] captured_count_reg;
  logic [3:0]  out_en_reg;
  logic [3:0]  channel_polarity_reg;
  logic [3:0]  duty_match_flag_reg;
  logic [11:0] duty_cycle_value_reg [NUM_CH];
  logic [2:0]  ctrl_reg;
  logic        fault_reg;
  logic [4:0]  slow_cnt_reg;
  logic        cap_in_reg;
  logic [3:0]  pwm_raw_reg;
  logic [31:0] rdata_next;

  // address phase decode; data phase acts on the stored request
  wire         addr_take = HSEL && HREADY && HTRANS == HTRANS_NSEQ;
  wire         wr_go     = phase_reg == PH_DATA && req_reg.sel && req_reg.write;
  wire         rd_go     = phase_reg == PH_DATA && req_reg.sel && !req_reg.write;
  wire [7:0]   wa        = req_reg.addr;
  wire         ch_area   = wa >= OFF_CH_CSR && wa < OFF_CH_CSR + 8'h20;
  wire [1:0]   ch_idx    = 2'((wa - OFF_CH_CSR) >> 3);
  wire         ch_is_dut = wa[2];

  // timer tick: divided by thirty-two in slow state; idle has no effect
  wire         timed_run = ctrl_reg[CTRL_SEL0] && !ctrl_reg[CTRL_SEL1] && ctrl_reg[CTRL_OVERFLOW_IRQ_ENABLE];
  wire         halted    = STOP_MODE || (TIMED_STOP_MODE && !timed_run);
  wire         tick      = !halted && (!SLOW_MODE || slow_cnt_reg == SLOW_LAST);
  wire         overflow  = tick && up_count_reg == CNT_MAX;
  wire         cap_edge  = CAPTURE_INPUT && !cap_in_reg;

  // read mux; unmapped words read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (ch_area) begin
      if (ch_is_dut)
        rdata_next = {20'h0_0000, duty_cycle_value_reg[ch_idx]};
      else
        rdata_next = {30'h0000_0000, channel_polarity_reg[ch_idx], duty_match_flag_reg[ch_idx]};
    end else begin
      case (wa)
        OFF_RLD_HI: rdata_next = {28'h000_0000, reload_value_reg[11:8]};
        OFF_RLD_LO: rdata_next = {24'h00_0000, reload_value_reg[7:0]};
        OFF_CAP_HI: rdata_next = {28'h000_0000, captured_count_reg[11:8]};
        OFF_CAP_LO: rdata_next = {24'h00_0000, captured_count_reg[7:0]};
        OFF_OUT_EN: rdata_next = {28'h000_0000, out_en_reg};
        OFF_FAULT:  rdata_next = {26'h000_0000, fault_reg, 5'h00};
        OFF_CTRL:   rdata_next = {29'h0000_0000, ctrl_reg};
        OFF_COUNT:  rdata_next = {20'h0_0000, up_count_reg};
        default:    rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // bus phase tracking and read data register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      phase_reg <= PH_IDLE;
      req_reg   <= '0;
      HRDATA    <= 32'h0000_0000;
    end else begin
      if (rd_go)
        HRDATA <= rdata_next;
      if (HREADY) begin
        phase_reg <= addr_take ? PH_DATA : PH_IDLE;
        req_reg   <= '{sel: addr_take, write: HWRITE, addr: HADDR[7:0]};
      end
    end
  end

  // read data is registered, so the data phase takes one wait state
  always_ff @(posedge CLK) begin
    if (!RST_N)
      HREADYOUT <= 1'b1;
    else
      HREADYOUT <= !(addr_take && !HWRITE && HREADYOUT);
  end

  always_ff @(posedge CLK) begin
    HRESP <= 1'b0;
  end

  // software registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      reload_value_reg <= {4'h0, RST_BYTE};
      out_en_reg       <= 4'h0;
      ctrl_reg         <= 3'h0;
    end else if (wr_go) begin
      if (wa == OFF_RLD_HI)
        reload_value_reg[11:8] <= HWDATA[3:0];
      if (wa == OFF_RLD_LO)
        reload_value_reg[7:0] <= HWDATA[7:0];
      if (wa == OFF_OUT_EN)
        out_en_reg <= HWDATA[3:0];
      if (wa == OFF_CTRL)
        ctrl_reg <= HWDATA[2:0];
    end
  end

  // fault-stop: pin low sets, software may write either way; pin wins
  always_ff @(posedge CLK) begin
    if (!RST_N)
      fault_reg <= 1'b0;
    else if (!FAULT_STOP_N)
      fault_reg <= 1'b1;
    else if (wr_go && wa == OFF_FAULT)
      fault_reg <= HWDATA[FAULT_BIT];
  end

  // slow-state prescaler
  always_ff @(posedge CLK) begin
    if (!RST_N)
      slow_cnt_reg <= 5'h00;
    else if (!halted && SLOW_MODE)
      slow_cnt_reg <= slow_cnt_reg + 5'h01;
    else
      slow_cnt_reg <= 5'h00;
  end

  // upcounter with reload on overflow
  always_ff @(posedge CLK) begin
    if (!RST_N)
      up_count_reg <= 12'h000;
    else if (overflow)
      up_count_reg <= reload_value_reg;
    else if (tick)
      up_count_reg <= up_count_reg + 12'h001;
  end

  // capture the count on a rising capture input
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cap_in_reg         <= 1'b0;
      captured_count_reg <= 12'h000;
    end else begin
      cap_in_reg <= CAPTURE_INPUT;
      if (cap_edge)
        captured_count_reg <= up_count_reg;
    end
  end

  // per-channel logic
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      wire ch_sel   = ch_area && ch_idx == 2'(g);
      wire match    = tick && up_count_reg == duty_cycle_value_reg[g];
      wire csr_read = rd_go && ch_sel && !ch_is_dut;
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          channel_polarity_reg[g] <= 1'b0;
          duty_cycle_value_reg[g] <= 12'h000;
          duty_match_flag_reg[g]  <= 1'b0;
          pwm_raw_reg[g]          <= 1'b0;
        end else begin
          if (wr_go && ch_sel && !ch_is_dut)
            channel_polarity_reg[g] <= HWDATA[CSR_POL_BIT];
          if (wr_go && ch_sel && ch_is_dut)
            duty_cycle_value_reg[g] <= HWDATA[11:0];
          // a match in the read cycle wins over the clear
          if (match)
            duty_match_flag_reg[g] <= 1'b1;
          else if (csr_read)
            duty_match_flag_reg[g] <= 1'b0;
          if (overflow)
            pwm_raw_reg[g] <= 1'b1;
          else if (match)
            pwm_raw_reg[g] <= 1'b0;
        end
      end
      // pin drive and enable registered straight from state
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          PWM_OUT[g]    <= 1'b0;
          PWM_OUT_EN[g] <= 1'b0;
        end else begin
          PWM_OUT[g]    <= pwm_raw_reg[g] ^ channel_polarity_reg[g];
          PWM_OUT_EN[g] <= out_en_reg[g];
        end
      end
    end
  endgenerate

  // assertions
  a_reload_on_ovf: assert property (@(posedge CLK) disable iff (!RST_N)
    overflow |=> up_count_reg == $past(reload_value_reg))
    else $error("counter not reloaded on overflow");
  a_halt_in_stop: assert property (@(posedge CLK) disable iff (!RST_N)
    STOP_MODE |=> up_count_reg == $past(up_count_reg))
    else $error("counter moved in stop state");
  a_slow_divide: assert property (@(posedge CLK) disable iff (!RST_N)
    (SLOW_MODE && !halted && slow_cnt_reg != SLOW_LAST && !overflow) |=> $stable(up_count_reg))
    else $error("counter moved between slow ticks");
  a_fault_sets: assert property (@(posedge CLK) disable iff (!RST_N)
    !FAULT_STOP_N |=> fault_reg)
    else $error("fault bit not set by low pin");
  a_reload_hi_read: assert property (@(posedge CLK) disable iff (!RST_N)
    (rd_go && wa == OFF_RLD_HI) |=> HRDATA[31:4] == 28'h000_0000)
    else $error("reload high upper bits not zero");
  a_flag_on_match: assert property (@(posedge CLK) disable iff (!RST_N)
    (tick && up_count_reg == duty_cycle_value_reg[0]) |=> duty_match_flag_reg[0])
    else $error("compare flag not set on match");
  a_pwm_high_ovf: assert property (@(posedge CLK) disable iff (!RST_N)
    overflow |=> pwm_raw_reg[1] ##1 PWM_OUT[1] == !channel_polarity_reg[1])
    else $error("pwm not high after overflow");
  a_oe_follows: assert property (@(posedge CLK) disable iff (!RST_N)
    ##1 PWM_OUT_EN == $past(out_en_reg))
    else $error("output enable mismatch");
  a_capture_take: assert property (@(posedge CLK) disable iff (!RST_N)
    cap_edge |=> captured_count_reg == $past(up_count_reg))
    else $error("capture missed");
endmodule // reload_timer
`default_nettype wire

//--- reload_timer_pkg.sv
// Purpose: constants, register map and types for the auto-reload pwm timer
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes: register offsets are local choices; all numbers live here
package reload_timer_pkg;
  localparam int          CNT_W        = 12;
  localparam int          NUM_CH       = 4;
  localparam int          SLOW_DIV     = 32;
  localparam logic [4:0]  SLOW_LAST    = 5'h1F;
  localparam logic [11:0] CNT_MAX      = 12'hFFF;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  // word offsets
  localparam logic [7:0]  OFF_RLD_HI   = 8'h00;
  localparam logic [7:0]  OFF_RLD_LO   = 8'h04;
  localparam logic [7:0]  OFF_CAP_HI   = 8'h08;
  localparam logic [7:0]  OFF_CAP_LO   = 8'h0C;
  localparam logic [7:0]  OFF_OUT_EN   = 8'h10;
  localparam logic [7:0]  OFF_FAULT    = 8'h14;
  localparam logic [7:0]  OFF_CTRL     = 8'h18;
  localparam logic [7:0]  OFF_COUNT    = 8'h1C;
  localparam logic [7:0]  OFF_CH_CSR   = 8'h20;  // csr of channel n at +8*n
  localparam logic [7:0]  OFF_CH_DUTY  = 8'h24;  // duty of channel n at +8*n
  // field positions
  localparam int          CSR_FLAG_BIT = 0;
  localparam int          CSR_POL_BIT  = 1;
  localparam int          FAULT_BIT    = 5;
  localparam int          CTRL_SEL0    = 0;
  localparam int          CTRL_SEL1    = 1;
  localparam int          CTRL_OVERFLOW_IRQ_ENABLE   = 2;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  typedef enum logic [1:0] {PWR_RUN, PWR_SLOW, PWR_IDLE, PWR_STOP_TIMED} pwr_unused_t;
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } bus_req_t;
endpackage

//--- tb_autoreload_pwm_timer.sv
// Purpose: self-checking bench for the auto-reload pwm timer
// Assumes: single AHB-Lite slave, hready fed back from hreadyout
// Notes: counter halted in stop mode to make capture and flag checks exact
`timescale 1ns/1ps
`default_nettype none
module tb_autoreload_pwm_timer;
  import reload_timer_pkg::*;
  logic        CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, cap_req, fault_req;
  logic        SLOW_MODE, IDLE_MODE, STOP_MODE, TIMED_STOP_MODE, CAPTURE_INPUT, FAULT_STOP_N;
  logic [31:0] HADDR, HWDATA, HRDATA, d, e, f, seed;
  logic [1:0]  HTRANS;
  logic [3:0]  PWM_OUT, PWM_OUT_EN;
  int          err_count, n_tests, hi;
  reload_timer i_reload_timer (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SLOW_MODE(SLOW_MODE), .IDLE_MODE(IDLE_MODE),
    .STOP_MODE(STOP_MODE), .TIMED_STOP_MODE(TIMED_STOP_MODE), .CAPTURE_INPUT(CAPTURE_INPUT),
    .FAULT_STOP_N(FAULT_STOP_N), .PWM_OUT(PWM_OUT), .PWM_OUT_EN(PWM_OUT_EN));
  pin_load_model i_pin_load_model (.CLK(CLK), .cap_req(cap_req), .fault_req(fault_req), .PWM_OUT(PWM_OUT),
    .PWM_OUT_EN(PWM_OUT_EN), .CAPTURE_INPUT(CAPTURE_INPUT), .FAULT_STOP_N(FAULT_STOP_N));
  // clock and watchdog; the whole run needs well under 20000 cycles
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial begin
    #160000;
    err_count++;
    results();
  end
  task automatic results();
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one AHB single transfer; waits are bounded, read data taken at the data-phase edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    HSEL <= 1'b1; HTRANS <= HTRANS_NSEQ; HADDR <= {24'h000000, a}; HWRITE <= w;
    n = 0;
    do begin @(posedge CLK); n++; end while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50) err_count++;  // a stuck address phase counts as a mismatch
    HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= wd;
    n = 0;
    do begin @(posedge CLK); n++; end while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50) err_count++;  // a stuck data phase counts as a mismatch
    rd = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    xfer(1'b0, a, 32'h00000000, x);
  endtask
  function automatic logic [31:0] delta(input logic [31:0] a, input logic [31:0] b);
    return {20'h00000, b[11:0] - a[11:0]};
  endfunction
  // counter value after n ticks, reloading past all ones
  function automatic logic [31:0] adv(input logic [31:0] a, input int n, input logic [11:0] rl);
    logic [11:0] c;
    c = a[11:0];
    for (int k = 0; k < n; k++) c = (c == CNT_MAX) ? rl : c + 12'h001;
    return {20'h00000, c};
  endfunction
  initial begin
    {HSEL, HWRITE, HADDR, HWDATA, HTRANS, cap_req, fault_req} = '0;
    {SLOW_MODE, IDLE_MODE, STOP_MODE, TIMED_STOP_MODE} = '0;
    err_count = 0; n_tests = 0; seed = 32'hAC34; RST_N = 1'b0;
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    // reset values of reload and enable registers
    rd(OFF_RLD_HI, d); chk(d, 32'h00000000);
    rd(OFF_RLD_LO, d); chk(d, 32'h00000000);
    rd(OFF_OUT_EN, d); chk(d, 32'h00000000);
    // random reload values; high register keeps only four bits
    for (int i = 0; i < 6; i++) begin
      e = $random(seed);
      wr(OFF_RLD_HI, e); wr(OFF_RLD_LO, {e[7:0], e[31:8]});
      rd(OFF_RLD_HI, d); chk(d, {28'h0000000, e[3:0]});
      rd(OFF_RLD_LO, d); chk(d, {24'h000000, e[15:8]});
    end
    rd(8'hF0, d); chk(d, 32'h00000000);  // unmapped place reads zero
    // period 16 ticks, duty match 8 ticks after reload; channel 1 inverted
    wr(OFF_RLD_HI, 32'h0000000F); wr(OFF_RLD_LO, 32'h000000F0);
    wr(OFF_CH_DUTY, 32'h00000FF8); wr(OFF_CH_DUTY + 8'h08, 32'h00000FF8);
    wr(OFF_CH_CSR + 8'h08, 32'h00000002); wr(OFF_OUT_EN, 32'h00000003);
    repeat (4200) @(posedge CLK);
    chk({28'h0, PWM_OUT_EN}, 32'h00000003);
    hi = 0;
    for (int i = 0; i < 64; i++) begin
      @(negedge CLK);
      hi += PWM_OUT[0];
      chk({31'h0, PWM_OUT[1]}, {31'h0, ~PWM_OUT[0]});
    end
    chk(hi, 32'd36);
    rd(OFF_COUNT, d); chk({31'h0, d[11:0] >= 12'hFF0}, 32'h1);
    // halted counter: stable count, flag cleared by reading, exact capture
    @(posedge CLK) STOP_MODE <= 1'b1;
    rd(OFF_COUNT, e); rd(OFF_COUNT, d); chk(d, e);
    rd(OFF_CH_CSR, d); chk(d & 32'h1, 32'h1);
    rd(OFF_CH_CSR, d); chk(d & 32'h1, 32'h0);
    cap_req <= 1'b1;
    repeat (4) @(posedge CLK);
    rd(OFF_CAP_HI, d); rd(OFF_CAP_LO, f);
    chk({d[23:0], f[7:0]}, {20'h00000, e[11:0]});
    // timed low-power: halted unless sel0=1, sel1=0, overflow enable=1
    STOP_MODE <= 1'b0; TIMED_STOP_MODE <= 1'b1;
    wr(OFF_CTRL, 32'h00000000);
    rd(OFF_COUNT, e); rd(OFF_COUNT, d); chk(d, e);
    wr(OFF_CTRL, 32'h00000005);
    rd(OFF_COUNT, e); rd(OFF_COUNT, d); chk({31'h0, d !== e}, 32'h1);
    TIMED_STOP_MODE <= 1'b0; IDLE_MODE <= 1'b1;
    rd(OFF_COUNT, e); rd(OFF_COUNT, d); chk(d, adv(e, 3, 12'hFF0));
    // reduced clock: about ten ticks in 320 clocks
    IDLE_MODE <= 1'b0; SLOW_MODE <= 1'b1;
    wr(OFF_RLD_HI, 32'h0); wr(OFF_RLD_LO, 32'h0);
    rd(OFF_COUNT, e);
    repeat (317) @(posedge CLK);
    rd(OFF_COUNT, d);
    chk({31'h0, delta(e, d) >= 32'd9 && delta(e, d) <= 32'd11}, 32'h1);
    // fault pin low forces the bit; software clears it once the pin is released
    fault_req <= 1'b1;
    repeat (3) @(posedge CLK);
    rd(OFF_FAULT, d); chk(d & 32'h20, 32'h20);
    fault_req <= 1'b0;
    repeat (3) @(posedge CLK);
    wr(OFF_FAULT, 32'h0); rd(OFF_FAULT, d); chk(d & 32'h20, 32'h0);
    results();
  end
endmodule // tb_autoreload_pwm_timer
`default_nettype wire
